// >>> hw/sslt_consts.svh
/*
  constants for the serial segment shift latch: widths, fifo depth, timing.
  assumes inclusion by bare name from package and design files.
*/
`ifndef SSLT_CONSTS_SVH
`define SSLT_CONSTS_SVH
`define SSLT_NUM_SEG 80
`define SSLT_FIFO_DEPTH 4
`define SSLT_CLK_PERIOD_NS 5
`define SSLT_LVL_TOP 2'h0
`define SSLT_LVL_UPPER_MID 2'h1
`define SSLT_LVL_LOWER_MID 2'h2
`define SSLT_LVL_BOTTOM 2'h3
`endif

// >>> hw/sslt_pkg.sv
/*
  types for the serial segment shift latch.
  assumes sslt_consts.svh on the include path.
*/
`include "sslt_consts.svh"
package sslt_pkg;
  typedef logic [1:0] sslt_level_t;
  typedef struct packed {
    logic shiftClock;
    logic pixel;
    logic latchPulse;
    logic dirSelect;
    logic framePol;
  } sslt_link_t;
  typedef struct packed {
    logic pixel;
    logic dirSelect;
  } sslt_word_t;
endpackage

// >>> hw/serial_segment_shift_latch.sv
/*
  segment driver data path: pin sampling, edge detect, 4-word fifo,
  bidirectional 80-stage shift register, display latch, level select.
  assumes link pins are asynchronous to clk and much slower than it.
  assumes every link pin holds each level for at least three clk periods,
  so the two-stage synchronisers never miss a shift or latch edge.
  assumes the controller keeps data steady a few clk around each shift fall.
  limitation: shift edges that arrive while the fifo is full are lost;
  shiftStall reports that case, which slow link rates never reach.
  the level codes only name a drive level; the analogue stage is outside.
*/
// Behaviour
// - an 80-stage shift register, one stage per segment output, fillable both ways.
// - data sampled and register advanced on each shift clock falling edge.
// - direction low: data enters stage 0 and moves toward stage 79.
// - direction high: data enters stage 79 and moves toward stage 0.
// - latch pulse falling edge copies all stages into the display latch.
// - latched outputs stay stable between latch pulses and frame flips; shifting leaves them alone.
// - latched bit and frame polarity choose one of four drive levels.
`timescale 1ns/1ps
`default_nettype none
`include "sslt_consts.svh"

module sslt_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = `SSLT_FIFO_DEPTH
) (
  input wire logic clk, // core clock
  input wire logic rst, // async reset
  input wire logic ce, // clock enable
  input wire logic inValid, // write request
  output logic inReady, // room left
  input wire logic [WIDTH-1:0] inData, // write word
  output logic outValid, // word available
  input wire logic outReady, // consumer takes word
  output logic [WIDTH-1:0] outData // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [AW:0] count, next_count;
  logic doWr, doRd;

  // pointer step that wraps at the last slot; shared by both pointers
  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] ptr);
    logic [AW-1:0] nxt;
    nxt = (ptr == AW'(DEPTH - 1)) ? '0 : ptr + 1'h1;
    return nxt;
  endfunction

  always_comb begin
    doWr = inValid && inReady;
    doRd = outValid && outReady;
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    if (doWr) begin
      next_wrPtr = wrap_inc(wrPtr);
    end
    if (doRd) begin
      next_rdPtr = wrap_inc(rdPtr);
    end
    next_count = count + (AW+1)'(doWr) - (AW+1)'(doRd);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (ce) begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // storage: one comb for the next words, one ff per word that only registers
  logic [WIDTH-1:0] next_mem [DEPTH];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = mem[i];
    end
    if (doWr) begin
      next_mem[wrPtr] = inData;
    end
  end

  // words are reset too, so a stray read after reset shows zero, not x
  genvar w;
  generate
    for (w = 0; w < DEPTH; w++) begin : gWord
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mem[w] <= '0;
        end else if (ce) begin
          mem[w] <= next_mem[w];
        end
      end
    end
  endgenerate

  // flags come from the count alone, so full and empty never disagree
  always_comb begin
    inReady = (count != (AW+1)'(DEPTH));
    outValid = (count != '0);
    outData = mem[rdPtr];
  end
endmodule

module serial_segment_shift_latch #(
  parameter int NUM_SEG = `SSLT_NUM_SEG,
  parameter int FIFO_DEPTH = `SSLT_FIFO_DEPTH
) (
  input wire logic clk, // core clock, 200 MHz
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable, freezes all state when low
  input wire sslt_pkg::sslt_link_t linkIn, // raw pins from the controller
  output logic serialPixelOut, // far-end bit for chaining
  output logic shiftStall, // fifo full: a shift edge would be lost
  output sslt_pkg::sslt_level_t driveLevel [NUM_SEG] // per-segment level code
);
  import sslt_pkg::*;

  // two-stage synchronisers; stage one is read only by stage two
  sslt_link_t syncA, syncB, syncPrev;
  sslt_link_t next_syncA, next_syncB, next_syncPrev;
  logic shiftFall, latchFall;

  // syncPrev keeps the last settled copy so edges are found one clk later
  always_comb begin
    next_syncA = linkIn;
    next_syncB = syncA;
    next_syncPrev = syncB;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA <= '0;
      syncB <= '0;
      syncPrev <= '0;
    end else if (ce) begin
      syncA <= next_syncA;
      syncB <= next_syncB;
      syncPrev <= next_syncPrev;
    end
  end

  // data sits stable around the edge, so the synced copy at the fall is good
  // falling-edge test shared by the shift and latch pins
  function automatic logic fell(input logic prev, input logic cur);
    return prev && !cur;
  endfunction

  always_comb begin
    shiftFall = fell(syncPrev.shiftClock, syncB.shiftClock);
    latchFall = fell(syncPrev.latchPulse, syncB.latchPulse);
  end

  sslt_word_t inWord, headWord;
  logic fifoInReady, fifoOutValid, fifoOutReady;
  logic framePolSync;

  // frame polarity is read only from its synchronised copy
  always_comb begin
    inWord.pixel = syncB.pixel;
    inWord.dirSelect = syncB.dirSelect;
    framePolSync = syncB.framePol;
  end

  // a latch edge must see every earlier shift, so it waits for the fifo to drain
  typedef enum logic {LATCH_IDLE, LATCH_WAIT} sslt_latch_state_t;
  sslt_latch_state_t latchState, next_latchState;
  logic latchWanted;

  sslt_fifo #(
    .WIDTH($bits(sslt_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .inValid(shiftFall),
    .inReady(fifoInReady),
    .inData(inWord),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(headWord)
  );

  logic [NUM_SEG-1:0] shiftReg, next_shiftReg;
  logic [NUM_SEG-1:0] dispLatch, next_dispLatch;
  logic next_serialPixelOut, next_shiftStall;

  // one shift step; a high select runs the shift from stage 79 toward stage 0
  function automatic logic [NUM_SEG-1:0] shift_step(input logic [NUM_SEG-1:0] cur,
      input logic bitIn, input logic toLow);
    logic [NUM_SEG-1:0] nxt;
    if (toLow) begin
      nxt = {bitIn, cur[NUM_SEG-1:1]};
    end else begin
      nxt = {cur[NUM_SEG-2:0], bitIn};
    end
    return nxt;
  endfunction

  // far end of the register for the chain output, per shift direction
  function automatic logic far_end(input logic [NUM_SEG-1:0] cur, input logic toLow);
    logic bitOut;
    bitOut = toLow ? cur[0] : cur[NUM_SEG-1];
    return bitOut;
  endfunction

  // the register always drains the fifo; a latch copy waits for it instead
  always_comb begin
    fifoOutReady = 1'h1;
    next_shiftReg = shiftReg;
    if (fifoOutValid) begin
      next_shiftReg = shift_step(shiftReg, headWord.pixel, headWord.dirSelect);
    end
  end

  always_comb begin
    latchWanted = (latchState == LATCH_WAIT) || latchFall;
    next_latchState = latchState;
    next_dispLatch = dispLatch;
    unique case (latchState)
      LATCH_IDLE: begin
        if (latchFall) begin
          next_latchState = LATCH_WAIT;
        end
      end
      LATCH_WAIT: begin
        next_latchState = LATCH_WAIT;
      end
    endcase
    // copy only once every queued shift has landed in the register
    if (latchWanted && !fifoOutValid) begin
      next_dispLatch = shiftReg;
      next_latchState = LATCH_IDLE;
    end
    // far end follows the current direction select
    next_serialPixelOut = far_end(next_shiftReg, syncB.dirSelect);
    next_shiftStall = !fifoInReady;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shiftReg <= '0;
      dispLatch <= '0;
      latchState <= LATCH_IDLE;
      serialPixelOut <= 1'h0;
      shiftStall <= 1'h0;
    end else if (ce) begin
      shiftReg <= next_shiftReg;
      dispLatch <= next_dispLatch;
      latchState <= next_latchState;
      serialPixelOut <= next_serialPixelOut;
      shiftStall <= next_shiftStall;
    end
  end

  function automatic sslt_level_t pick_level(input logic on, input logic frame);
    sslt_level_t lvl;
    lvl = `SSLT_LVL_TOP;
    if (on && frame) begin
      lvl = `SSLT_LVL_BOTTOM;
    end else if (on) begin
      lvl = `SSLT_LVL_TOP;
    end else if (frame) begin
      lvl = `SSLT_LVL_LOWER_MID;
    end else begin
      lvl = `SSLT_LVL_UPPER_MID;
    end
    return lvl;
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_SEG; g++) begin : gSeg
      sslt_level_t next_level;
      always_comb begin
        // a frame flip acts at once; the latched bit only on a latch copy
        next_level = pick_level(next_dispLatch[g], framePolSync);
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          driveLevel[g] <= `SSLT_LVL_UPPER_MID;
        end else if (ce) begin
          driveLevel[g] <= next_level;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> tb/sslt_checker.sv
/* port assertions for the shift latch.
   assumes a bind from the bench top. */
`timescale 1ns/1ps
`default_nettype none
module sslt_checker #(
  parameter int NUM_SEG = 80
) (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire sslt_pkg::sslt_link_t linkIn, // pins
  input wire logic serialPixelOut, // chain
  input wire logic shiftStall, // full
  input wire sslt_pkg::sslt_level_t driveLevel [NUM_SEG] // levels
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_st; !shiftStall; endproperty
  a_st: assert property (p_st) else $error("stall");
  property p_hd; ($stable(linkIn.latchPulse) && $stable(linkIn.framePol))[*8]
    |-> $stable(driveLevel[0]) && $stable(driveLevel[NUM_SEG-1]); endproperty
  a_hd: assert property (p_hd) else $error("hold");
  property p_f0; ($stable(linkIn.framePol))[*5]
    |-> driveLevel[0][1] == linkIn.framePol; endproperty
  a_f0: assert property (p_f0) else $error("frame");
  property p_fn; ($stable(linkIn.framePol))[*5]
    |-> driveLevel[NUM_SEG-1][1] == linkIn.framePol; endproperty
  a_fn: assert property (p_fn) else $error("frame");
  // a polarity flip alone inverts both code bits
  property p_s0; ($stable(linkIn.latchPulse))[*8] ##0 $changed(linkIn.framePol)
    |-> ##4 driveLevel[0] == 2'h3 - $past(driveLevel[0], 4); endproperty
  a_s0: assert property (p_s0) else $error("swap");
  property p_sn; ($stable(linkIn.latchPulse))[*8] ##0 $changed(linkIn.framePol)
    |-> ##4 driveLevel[NUM_SEG-1] == 2'h3 - $past(driveLevel[NUM_SEG-1], 4); endproperty
  a_sn: assert property (p_sn) else $error("swap");
  property p_ch; ($stable(linkIn.shiftClock) && $stable(linkIn.dirSelect))[*8]
    |-> $stable(serialPixelOut); endproperty
  a_ch: assert property (p_ch) else $error("chain");
  property p_rs; disable iff (1'b0) rst && $past(rst) |-> driveLevel[0] == 2'h1 && !serialPixelOut;
  endproperty
  a_rs: assert property (p_rs) else $error("reset");
endmodule
`default_nettype wire

// >>> tb/sslt_ctrl_model.sv
/* controller model driving rows, latch and frame pins.
   assumes the bench calls one task at a time. */
`timescale 1ns/1ps
`default_nettype none
module sslt_ctrl_model (
  input wire logic clk, // bench clock
  output var sslt_pkg::sslt_link_t link // pins
);
  localparam int HALF = 16; // half of a 160 ns link period in clk
  initial link = 5'h10;
  // data flips once hold ends, so a stale bit cannot pass
  task automatic shift_row(input logic [79:0] row, input logic dir, input int slow);
    link.dirSelect <= dir;
    for (int i = 0; i < 80; i++) begin
      link.pixel <= row[i];
      repeat (HALF) @(posedge clk);
      link.shiftClock <= 1'h0;
      repeat (HALF / 2) @(posedge clk);
      link.pixel <= ~row[i];
      repeat (HALF / 2 + slow) @(posedge clk);
      link.shiftClock <= 1'h1;
    end
  endtask
  task automatic pulse_latch();
    repeat (8) @(posedge clk);
    link.latchPulse <= 1'h1;
    repeat (40) @(posedge clk);
    link.latchPulse <= 1'h0;
    @(posedge clk);
  endtask
  task automatic set_frame(input logic fr);
    link.framePol <= fr;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
/* bench top: model, driver, checker bind.
   assumes hw compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errorCnt++; \
  $display("CHECK FAILED %0t output got %h want %h", $time, a, e); end end
module tb;
  import sslt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fp = 1'b0;
  logic spo;
  logic [31:0] seed = 32'h48211b31;
  logic [79:0] bits = '0;
  int errorCnt = 0;
  int comparisons = 0;
  sslt_link_t link;
  sslt_level_t lvl [80];
  sslt_level_t code [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
  sslt_ctrl_model m (.clk(clk), .link(link));
  serial_segment_shift_latch DUT (.clk(clk), .rst(rst), .ce(1'b1), .linkIn(link),
    .serialPixelOut(spo), .shiftStall(), .driveLevel(lvl));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmpAll();
    for (int s = 0; s < 80; s++) `CHK(lvl[s], code[{bits[s], fp}])
  endtask
  task automatic closeOut();
    $display("errors %0d checks %0d", errorCnt, comparisons);
    if (errorCnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #2.5 clk = ~clk;
  initial begin
    #200us;
    errorCnt++;
    closeOut();
  end
  initial begin
    logic [79:0] r;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      r = 80'({rnd(), rnd(), rnd()});
      if (i == 2) r = '1;
      if (i == 3) r = '0;
      m.shift_row(r, i[0], i * 6);
      repeat (20) @(posedge clk);
      `CHK(spo, r[0])
      cmpAll();
      m.pulse_latch();
      repeat (20) @(posedge clk);
      for (int s = 0; s < 80; s++) bits[s] = i[0] ? r[s] : r[79 - s];
      cmpAll();
      fp = ~fp;
      m.set_frame(fp);
      repeat (20) @(posedge clk);
      cmpAll();
    end
    closeOut();
  end
endmodule
bind serial_segment_shift_latch sslt_checker #(.NUM_SEG(NUM_SEG)) chk (.clk(clk), .rst(rst),
  .linkIn(linkIn), .serialPixelOut(serialPixelOut), .shiftStall(shiftStall),
  .driveLevel(driveLevel));
`default_nettype wire
